// ---- aif_pkg.sv ----
package aif_pkg;
    // Clock and sample tick
    localparam int CLK_KHZ = 10000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_KHZ * TICK_MS;

    // Converter scaling and low-signal threshold (1 V of 10 V, 2 mA of 20 mA)
    localparam int ADC_W = 12;
    localparam int FS_CODE = 4095;
    localparam int LOW_PCT = 10;
    localparam logic [11:0] LOW_CODE = 12'(FS_CODE * LOW_PCT / 100);
    localparam int PCT_FS = 10000;
    localparam logic [17:0] CODE2PCT = 18'((PCT_FS * 65536) / FS_CODE);
    localparam logic signed [15:0] REF_MAX = 16'sh2710;

    // Filter coefficient numerator, Q16 per tick
    localparam int FLT_FW = 16;
    localparam int FLT_ONE = 65536;

    // Input modes
    localparam logic [3:0] IM_NPN = 4'h3;
    localparam logic [3:0] IM_PNP = 4'h4;
    localparam logic [3:0] IM_VOLT = 4'h6;
    localparam logic [3:0] IM_CURR = 4'h7;

    // Supervision modes
    localparam logic [1:0] SUP_OFF = 2'h0;
    localparam logic [1:0] SUP_WARN = 2'h1;
    localparam logic [1:0] SUP_RAMP = 2'h2;
    localparam logic [1:0] SUP_COAST = 2'h3;

    // Signal source numbers for the thermal-contact selector
    localparam logic [9:0] SRC_OFF = 10'h000;
    localparam logic [9:0] SRC_PROC = 10'h04d;
    localparam logic [9:0] SRC_RAW = 10'h214;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_FILT = 12'h004;
    localparam logic [11:0] OFS_X1 = 12'h008;
    localparam logic [11:0] OFS_Y1 = 12'h00c;
    localparam logic [11:0] OFS_X2 = 12'h010;
    localparam logic [11:0] OFS_Y2 = 12'h014;
    localparam logic [11:0] OFS_HOLD = 12'h018;
    localparam logic [11:0] OFS_TSEL = 12'h01c;
    localparam logic [11:0] OFS_STAT = 12'h020;
    localparam logic [11:0] OFS_ISTAT = 12'h024;
    localparam logic [11:0] OFS_IMASK = 12'h028;
    localparam logic [11:0] OFS_REF = 12'h02c;

    // Reset values
    localparam logic [3:0] RST_IMODE = IM_NPN;
    localparam logic [1:0] RST_SUP = SUP_OFF;
    localparam logic [12:0] RST_TC = 13'h0000;
    localparam logic [15:0] RST_X1 = 16'h00c8;
    localparam logic [15:0] RST_Y1 = 16'h0000;
    localparam logic [15:0] RST_X2 = 16'h2648;
    localparam logic [15:0] RST_Y2 = 16'h2710;
    localparam logic [15:0] RST_HOLD = 16'h03e8;
    localparam logic [9:0] RST_TSEL = SRC_RAW;

    // Interrupt status bits
    localparam int IRQ_W = 4;
    localparam int IB_WARN = 0;
    localparam int IB_TRIP = 1;
    localparam int IB_ERR = 2;
    localparam int IB_DIG = 3;

    localparam int DIV_W = 34;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_RAMP = 3'b001,
        ST_HOLD = 3'b010,
        ST_ERROR = 3'b011,
        ST_COAST = 3'b100
    } aif_state_t;
endpackage

// ---- aif_lpf.sv ----
`timescale 1ns/10ps
`default_nettype none
module aif_lpf #(
    parameter int DW = 12,
    parameter int FW = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Control
    input wire logic tick,
    input wire logic bypass,
    input wire logic [FW:0] coef,
    // Data
    input wire logic [DW-1:0] x,
    output logic [DW-1:0] y
);
    logic [DW+FW-1:0] acc_r;
    logic signed [DW+FW:0] err;
    logic signed [DW+2*FW+1:0] prod;
    logic signed [DW+FW:0] sum;

    // Step moves toward x, so the sum never leaves the unsigned range
    always_comb begin
        err = signed'({1'b0, x, FW'(0)}) - signed'({1'b0, acc_r});
        prod = err * signed'({1'b0, coef});
        sum = signed'({1'b0, acc_r}) + prod[DW+2*FW:FW];
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            acc_r <= '0;
        end else if (bypass) begin
            acc_r <= {x, FW'(0)};
        end else if (tick) begin
            acc_r <= sum[DW+FW-1:0];
        end
    end

    assign y = acc_r[DW+FW-1:FW];
endmodule
`default_nettype wire

// ---- aif_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module aif_monitor #(
    parameter int TICK_CYCLES = aif_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Input terminal
    input wire logic [11:0] adc_code,
    input wire logic pin_level,
    // Drive sequencing
    input wire logic start_cmd,
    input wire logic stop_done,
    output logic run_permit,
    output logic stop_ramp,
    output logic stop_coast,
    // Supervision and reference
    output logic warn,
    output logic fault,
    output logic error,
    output logic [11:0] filt_code,
    output logic signed [15:0] ref_out,
    // Digital sources
    output logic dig_proc,
    output logic dig_raw,
    output logic thermal_contact,
    // Interrupt
    output logic irq
);
    function automatic logic tc_legal(input logic [12:0] tc);
        case (tc)
            13'd0, 13'd2, 13'd4, 13'd8, 13'd16, 13'd32, 13'd64, 13'd128,
            13'd256, 13'd512, 13'd1000, 13'd2000, 13'd3000, 13'd4000,
            13'd5000: tc_legal = 1'b1;
            default: tc_legal = 1'b0;
        endcase
    endfunction

    // Coefficient is tick over tau in Q16; long constants lose resolution
    function automatic logic [16:0] tc_coef(input logic [12:0] tc);
        if (tc == 13'd0) begin
            tc_coef = 17'(aif_pkg::FLT_ONE);
        end else begin
            tc_coef = 17'(aif_pkg::FLT_ONE / int'(tc));
        end
    endfunction

    logic [3:0] imode_r;
    logic [1:0] supm_r;
    logic [12:0] tc_r;
    logic [16:0] coef_r;
    logic signed [15:0] x1_r, y1_r, x2_r, y2_r;
    logic [15:0] hold_r;
    logic [9:0] tsel_r;
    logic [aif_pkg::IRQ_W-1:0] istat_r, imask_r, ev;
    logic [31:0] rd_mux;
    logic addr_ok, wr_en;
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r;
    logic tick_r;
    logic analog, digital, low_now, pin_active, dig_prev_r;
    aif_pkg::aif_state_t state_r, state_nxt;
    logic [15:0] hold_cnt_r;
    logic [11:0] flt_y;

    // APB decode
    always_comb begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            aif_pkg::OFS_CTRL: rd_mux = {26'h0, supm_r, imode_r};
            aif_pkg::OFS_FILT: rd_mux = {19'h0, tc_r};
            aif_pkg::OFS_X1: rd_mux = {{16{x1_r[15]}}, x1_r};
            aif_pkg::OFS_Y1: rd_mux = {{16{y1_r[15]}}, y1_r};
            aif_pkg::OFS_X2: rd_mux = {{16{x2_r[15]}}, x2_r};
            aif_pkg::OFS_Y2: rd_mux = {{16{y2_r[15]}}, y2_r};
            aif_pkg::OFS_HOLD: rd_mux = {16'h0, hold_r};
            aif_pkg::OFS_TSEL: rd_mux = {22'h0, tsel_r};
            aif_pkg::OFS_STAT: rd_mux = {4'h0, flt_y, 5'h0, state_r, 2'h0,
                dig_proc, dig_raw, error, fault, warn, low_now};
            aif_pkg::OFS_ISTAT: rd_mux = {28'h0, istat_r};
            aif_pkg::OFS_IMASK: rd_mux = {28'h0, imask_r};
            aif_pkg::OFS_REF: rd_mux = {{16{ref_out[15]}}, ref_out};
            default: addr_ok = 1'b0;
        endcase
    end

    assign wr_en = psel && penable && pwrite && pready && addr_ok;

    // No wait state: answer registered during setup, ready in the first access cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= !addr_ok;
            end
        end
    end

    // Configuration
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            imode_r <= aif_pkg::RST_IMODE;
            supm_r <= aif_pkg::RST_SUP;
            tc_r <= aif_pkg::RST_TC;
            coef_r <= 17'(aif_pkg::FLT_ONE);
            hold_r <= aif_pkg::RST_HOLD;
            tsel_r <= aif_pkg::RST_TSEL;
            imask_r <= '0;
        end else if (wr_en) begin
            case (paddr)
                aif_pkg::OFS_CTRL: begin
                    if (pwdata[3:0] == aif_pkg::IM_NPN ||
                        pwdata[3:0] == aif_pkg::IM_PNP ||
                        pwdata[3:0] == aif_pkg::IM_VOLT ||
                        pwdata[3:0] == aif_pkg::IM_CURR) begin
                        imode_r <= pwdata[3:0];
                    end
                    supm_r <= pwdata[5:4];
                end
                aif_pkg::OFS_FILT: begin
                    if (pwdata[31:13] == 19'h0 && tc_legal(pwdata[12:0])) begin
                        tc_r <= pwdata[12:0];
                        coef_r <= tc_coef(pwdata[12:0]);
                    end
                end
                aif_pkg::OFS_HOLD: hold_r <= pwdata[15:0];
                aif_pkg::OFS_TSEL: tsel_r <= pwdata[9:0];
                aif_pkg::OFS_IMASK: imask_r <= pwdata[aif_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Characteristic points in 0.01 % units
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            x1_r <= aif_pkg::RST_X1;
            y1_r <= aif_pkg::RST_Y1;
            x2_r <= aif_pkg::RST_X2;
            y2_r <= aif_pkg::RST_Y2;
        end else if (wr_en) begin
            if (paddr == aif_pkg::OFS_X1) x1_r <= pwdata[15:0];
            if (paddr == aif_pkg::OFS_Y1) y1_r <= pwdata[15:0];
            if (paddr == aif_pkg::OFS_X2) x2_r <= pwdata[15:0];
            if (paddr == aif_pkg::OFS_Y2) y2_r <= pwdata[15:0];
        end
    end

    // Sample tick
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
            if (tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
                tick_cnt_r <= '0;
            end else begin
                tick_cnt_r <= tick_cnt_r + 1'b1;
            end
        end
    end

    aif_lpf #(
        .DW(aif_pkg::ADC_W),
        .FW(aif_pkg::FLT_FW)
    ) u_lpf (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .tick(tick_r),
        .bypass(tc_r == 13'd0),
        .coef(coef_r),
        .x(adc_code),
        .y(flt_y)
    );

    assign filt_code = flt_y;
    assign analog = imode_r == aif_pkg::IM_VOLT || imode_r == aif_pkg::IM_CURR;
    assign digital = imode_r == aif_pkg::IM_NPN || imode_r == aif_pkg::IM_PNP;
    // Same code threshold serves both ranges; no enable term on purpose
    assign low_now = analog && (flt_y < aif_pkg::LOW_CODE);

    // Supervision sequence
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            aif_pkg::ST_RUN: begin
                if (low_now && supm_r == aif_pkg::SUP_RAMP) begin
                    state_nxt = aif_pkg::ST_RAMP;
                end else if (low_now && supm_r == aif_pkg::SUP_COAST) begin
                    state_nxt = aif_pkg::ST_COAST;
                end
            end
            aif_pkg::ST_RAMP: if (stop_done) state_nxt = aif_pkg::ST_HOLD;
            aif_pkg::ST_HOLD:
                if (hold_cnt_r > hold_r) state_nxt = aif_pkg::ST_ERROR;
            aif_pkg::ST_ERROR, aif_pkg::ST_COAST:
                if (!start_cmd) state_nxt = aif_pkg::ST_RUN;
            default: state_nxt = aif_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_r <= aif_pkg::ST_RUN;
            hold_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r != aif_pkg::ST_HOLD) begin
                hold_cnt_r <= '0;
            end else if (tick_r && hold_cnt_r != 16'hffff) begin
                hold_cnt_r <= hold_cnt_r + 1'b1;
            end
        end
    end

    // Drive and supervision outputs
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            warn <= 1'b0;
            fault <= 1'b0;
            error <= 1'b0;
            stop_ramp <= 1'b0;
            stop_coast <= 1'b0;
            run_permit <= 1'b0;
        end else begin
            warn <= low_now && supm_r != aif_pkg::SUP_OFF;
            fault <= state_nxt != aif_pkg::ST_RUN;
            error <= state_nxt == aif_pkg::ST_ERROR;
            stop_ramp <= state_nxt == aif_pkg::ST_RAMP ||
                state_nxt == aif_pkg::ST_HOLD;
            stop_coast <= state_nxt == aif_pkg::ST_COAST;
            // Back in run only with start low, so a fresh edge is needed
            run_permit <= state_nxt == aif_pkg::ST_RUN && start_cmd;
        end
    end

    // Digital input
    assign pin_active = (imode_r == aif_pkg::IM_PNP) ? pin_level :
        !pin_level;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dig_raw <= 1'b0;
            dig_prev_r <= 1'b0;
            dig_proc <= 1'b0;
            thermal_contact <= 1'b0;
        end else begin
            dig_raw <= digital && pin_active;
            if (tick_r) begin
                // Two equal ticks in a row before the processed view follows
                dig_prev_r <= digital && pin_active;
                if (dig_prev_r == (digital && pin_active)) begin
                    dig_proc <= dig_prev_r;
                end
            end
            unique case (tsel_r)
                aif_pkg::SRC_RAW: thermal_contact <= dig_raw;
                aif_pkg::SRC_PROC: thermal_contact <= dig_proc;
                default: thermal_contact <= 1'b0;
            endcase
        end
    end

    // Characteristic: serial divide once per tick, about 36 cycles
    logic [29:0] xp_prod;
    logic signed [16:0] dy, dx;
    logic signed [33:0] num;
    logic [aif_pkg::DIV_W-1:0] quo_r, num_mag;
    logic [16:0] den_mag, den_r;
    logic [17:0] rem_r, rem_sh;
    logic [5:0] div_cnt_r;
    logic div_busy_r, neg_r, den_zero_r;
    logic signed [35:0] res;

    always_comb begin
        xp_prod = 30'(flt_y) * 30'(aif_pkg::CODE2PCT);
        dy = 17'(y2_r) - 17'(y1_r);
        dx = signed'({3'b000, xp_prod[29:16]}) - 17'(x1_r);
        num = 34'(dy) * 34'(dx);
        num_mag = num[33] ? 34'(-num) : 34'(num);
        den_mag = 17'(x2_r) - 17'(x1_r);
        if (den_mag[16]) begin
            den_mag = 17'(-signed'(den_mag));
        end
        rem_sh = {rem_r[16:0], quo_r[aif_pkg::DIV_W-1]};
        res = 36'(neg_r ? -signed'({2'b00, quo_r}) : signed'({2'b00, quo_r}))
            + 36'(y1_r);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            div_busy_r <= 1'b0;
            div_cnt_r <= '0;
            quo_r <= '0;
            rem_r <= '0;
            den_r <= '0;
            neg_r <= 1'b0;
            den_zero_r <= 1'b0;
            ref_out <= 16'sh0000;
        end else if (!div_busy_r) begin
            if (tick_r) begin
                div_busy_r <= 1'b1;
                div_cnt_r <= 6'(aif_pkg::DIV_W);
                quo_r <= num_mag;
                rem_r <= '0;
                den_r <= den_mag;
                den_zero_r <= x2_r == x1_r;
                neg_r <= num[33] ^ (x2_r < x1_r);
            end
        end else if (div_cnt_r != 6'd0) begin
            div_cnt_r <= div_cnt_r - 1'b1;
            if (rem_sh >= {1'b0, den_r}) begin
                rem_r <= rem_sh - {1'b0, den_r};
                quo_r <= {quo_r[aif_pkg::DIV_W-2:0], 1'b1};
            end else begin
                rem_r <= rem_sh;
                quo_r <= {quo_r[aif_pkg::DIV_W-2:0], 1'b0};
            end
        end else begin
            div_busy_r <= 1'b0;
            if (den_zero_r) begin
                ref_out <= y1_r;
            end else if (res > 36'(aif_pkg::REF_MAX)) begin
                ref_out <= aif_pkg::REF_MAX;
            end else if (res < -36'(aif_pkg::REF_MAX)) begin
                ref_out <= -aif_pkg::REF_MAX;
            end else begin
                ref_out <= res[15:0];
            end
        end
    end

    // Interrupts: set wins over a same-cycle write-one clear
    always_comb begin
        ev = '0;
        ev[aif_pkg::IB_WARN] = (low_now && supm_r != aif_pkg::SUP_OFF) && !warn;
        ev[aif_pkg::IB_TRIP] = !fault && state_nxt != aif_pkg::ST_RUN;
        ev[aif_pkg::IB_ERR] = !error && state_nxt == aif_pkg::ST_ERROR;
        ev[aif_pkg::IB_DIG] = tick_r && dig_prev_r == (digital && pin_active)
            && dig_prev_r != dig_proc;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            istat_r <= '0;
            irq <= 1'b0;
        end else begin
            if (wr_en && paddr == aif_pkg::OFS_ISTAT) begin
                istat_r <= (istat_r & ~pwdata[aif_pkg::IRQ_W-1:0]) | ev;
            end else begin
                istat_r <= istat_r | ev;
            end
            irq <= |(istat_r & imask_r);
        end
    end
endmodule
`default_nettype wire

// ---- aif_monitor_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module aif_monitor_checker #(
    parameter int TICK_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Drive sequencing and supervision
    input wire logic start_cmd,
    input wire logic run_permit,
    input wire logic stop_ramp,
    input wire logic stop_coast,
    input wire logic warn,
    input wire logic fault,
    input wire logic error
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ramp_trip;
        $rose(stop_ramp);
    endsequence
    sequence s_coast_trip;
        $rose(stop_coast);
    endsequence
    sequence s_release;
        error && !start_cmd;
    endsequence

    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready late after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ramp_trip_flags: assert property (s_ramp_trip |-> warn && fault)
        else $error("ramp stop without flags");
    a_coast_trip_flags: assert property (s_coast_trip |-> warn && fault)
        else $error("coast stop without flags");
    a_stop_exclusive: assert property (!(stop_ramp && stop_coast))
        else $error("ramp and coast stop together");
    a_stop_blocks_run: assert property ((stop_ramp || stop_coast) |-> fault && !run_permit)
        else $error("stop with run permitted");
    a_error_ends_ramp: assert property (error |-> fault && !stop_ramp && !run_permit)
        else $error("error state flags wrong");
    a_error_release: assert property (s_release |=> !error && !fault)
        else $error("error kept after release");
    a_permit_start: assert property (run_permit |-> $past(start_cmd))
        else $error("run permitted without start");
    a_fault_cause: assert property ($rose(fault) |-> stop_ramp || stop_coast)
        else $error("fault without stop");
endmodule

bind aif_monitor aif_monitor_checker #(.TICK_CYCLES(TICK_CYCLES)) aif_monitor_checker_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .start_cmd(start_cmd),
    .run_permit(run_permit),
    .stop_ramp(stop_ramp),
    .stop_coast(stop_coast),
    .warn(warn),
    .fault(fault),
    .error(error)
);
`default_nettype wire

// ---- aif_src_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Source on the terminal; sampled on the clock, so a new level lands late
module aif_src_model (
    // Clock
    input wire logic clk_sys,
    // Wanted terminal state
    input wire logic [11:0] want_code,
    input wire logic want_level,
    // Terminal
    output logic [11:0] adc_code,
    output logic pin_level
);
    initial begin
        adc_code = 12'h000;
        pin_level = 1'h1;
    end
    always @(posedge clk_sys) begin
        adc_code <= want_code;
        pin_level <= want_level;
    end
endmodule
`default_nettype wire

// ---- aif_monitor_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module aif_monitor_tb;
    localparam int TCK = 20;
    typedef struct packed {
        logic [5:0] ctrl;
        logic [11:0] code;
        logic [2:0] pwr;
    } aif_row_t;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, pin_level;
    logic [11:0] want_code = 12'h000;
    logic want_level = 1'h1;
    logic start_cmd = 1'h1;
    logic stop_done = 1'h0;
    logic [11:0] adc_code, filt_code;
    logic run_permit, stop_ramp, stop_coast, warn, fault, error;
    logic dig_proc, dig_raw, thermal_contact, irq;
    logic signed [15:0] ref_out;
    int err_total = 0;
    int n_checks = 0;
    int n;
    logic [31:0] rv [11] = '{32'h0000_0003, 32'h0000_0000, 32'h0000_00c8,
        32'h0000_0000, 32'h0000_2648, 32'h0000_2710, 32'h0000_03e8,
        32'h0000_0214, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    logic [12:0] taus [15] = '{13'h0000, 13'h0002, 13'h0004, 13'h0008,
        13'h0010, 13'h0020, 13'h0040, 13'h0080, 13'h0100, 13'h0200,
        13'h03e8, 13'h07d0, 13'h0bb8, 13'h0fa0, 13'h1388};
    // Pin, warn and raw view packed as three bits
    aif_row_t rows [9] = '{{6'h06, 12'h064, 3'h4}, {6'h16, 12'h064, 3'h6},
        {6'h16, 12'h199, 3'h4}, {6'h17, 12'h198, 3'h6},
        {6'h17, 12'h7d0, 3'h4}, {6'h03, 12'h000, 3'h1},
        {6'h03, 12'h000, 3'h4}, {6'h04, 12'h000, 3'h5},
        {6'h04, 12'h000, 3'h0}};

    always #50 clk_sys = ~clk_sys;

    aif_src_model aif_src_model_inst (.clk_sys(clk_sys),
        .want_code(want_code), .want_level(want_level),
        .adc_code(adc_code), .pin_level(pin_level));
    aif_monitor #(.TICK_CYCLES(TCK)) aif_monitor_inst (.clk_sys(clk_sys),
        .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_code(adc_code), .pin_level(pin_level),
        .start_cmd(start_cmd), .stop_done(stop_done),
        .run_permit(run_permit), .stop_ramp(stop_ramp),
        .stop_coast(stop_coast), .warn(warn), .fault(fault),
        .error(error), .filt_code(filt_code), .ref_out(ref_out),
        .dig_proc(dig_proc), .dig_raw(dig_raw),
        .thermal_contact(thermal_contact), .irq(irq));

    task automatic print_verdict;
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys);
        while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0000_0000);
        chk(rd, e, "read");
    endtask
    task automatic wait_for(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 300) begin
            cyc(1);
            n++;
        end
    endtask

    initial begin
        cyc(2);
        rstn <= 1'h1;
        cyc(2);
        chk({ref_out, warn, fault, error, irq}, 32'h0000_0000, "rst outs");
        for (int i = 0; i < 11; i++) rdc(12'(4 * i), rv[i]);
        apb(1'h0, 12'h030, 32'h0000_0000);
        chk({er, rd[30:0]}, 32'h8000_0000, "unmapped");
        foreach (taus[i]) begin
            wr(aif_pkg::OFS_FILT, {19'h0_0000, taus[i]});
            rdc(aif_pkg::OFS_FILT, {19'h0_0000, taus[i]});
        end
        wr(aif_pkg::OFS_FILT, 32'h0000_0006);
        rdc(aif_pkg::OFS_FILT, 32'h0000_1388);
        wr(aif_pkg::OFS_FILT, 32'h0000_0000);
        foreach (rows[i]) begin
            wr(aif_pkg::OFS_CTRL, {26'h000_0000, rows[i].ctrl});
            want_code <= rows[i].code;
            want_level <= rows[i].pwr[2];
            cyc(5);
            chk(warn, rows[i].pwr[1], "warn");
            chk({fault, run_permit}, 32'h0000_0001, "no trip");
            chk(dig_raw, rows[i].pwr[0], "raw");
        end
        want_code <= 12'h0fa0;
        cyc(3);
        chk(filt_code, 32'h0000_0fa0, "unfiltered");
        want_code <= 12'h000;
        cyc(3);
        chk(filt_code, 32'h0000_0000, "unfiltered");
        wr(aif_pkg::OFS_FILT, 32'h0000_0002);
        want_code <= 12'h0fa0;
        n = 0;
        while (filt_code === 12'h000 && n < 100) begin
            cyc(1);
            n++;
        end
        chk(filt_code, 32'h0000_07d0, "first tick");
        wr(aif_pkg::OFS_Y1, 32'hffff_f448);
        wr(aif_pkg::OFS_Y2, 32'hffff_f448);
        rdc(aif_pkg::OFS_Y1, 32'hffff_f448);
        cyc(80);
        chk({16'h0000, ref_out}, 32'h0000_f448, "flat ref");
        wr(aif_pkg::OFS_Y1, 32'h0000_0000);
        wr(aif_pkg::OFS_Y2, 32'h0000_2710);
        wr(aif_pkg::OFS_FILT, 32'h0000_0000);
        want_code <= 12'hfff;
        cyc(80);
        chk({16'h0000, ref_out}, 32'h0000_2710, "clamped ref");
        wr(aif_pkg::OFS_X1, 32'h0000_03e8);
        // No inverter enable exists: trips below run on start alone
        wr(aif_pkg::OFS_CTRL, 32'h0000_0036);
        want_code <= 12'h064;
        cyc(5);
        chk({stop_coast, fault, warn, run_permit, stop_ramp}, 32'h0000_001c,
            "coast trip");
        want_code <= 12'h7d0;
        cyc(3);
        start_cmd <= 1'h0;
        cyc(3);
        chk({fault, stop_coast}, 32'h0000_0000, "coast clear");
        start_cmd <= 1'h1;
        cyc(3);
        chk(run_permit, 32'h0000_0001, "restart");
        wr(aif_pkg::OFS_HOLD, 32'h0000_0003);
        wr(aif_pkg::OFS_CTRL, 32'h0000_0026);
        want_code <= 12'h064;
        cyc(5);
        chk({stop_ramp, fault, warn, run_permit}, 32'h0000_000e,
            "ramp trip");
        stop_done <= 1'h1;
        wait_for(error, 1'h1);
        chk(n >= 3 * TCK, 32'h0000_0001, "hold span");
        chk({error, stop_ramp, fault}, 32'h0000_0005, "error");
        want_code <= 12'h7d0;
        stop_done <= 1'h0;
        cyc(5);
        chk({error, run_permit}, 32'h0000_0002, "no restart");
        start_cmd <= 1'h0;
        cyc(2);
        chk({error, fault}, 32'h0000_0000, "error clear");
        start_cmd <= 1'h1;
        cyc(3);
        chk(run_permit, 32'h0000_0001, "restart");
        wr(aif_pkg::OFS_ISTAT, 32'h0000_000f);
        wr(aif_pkg::OFS_IMASK, 32'h0000_0001);
        wr(aif_pkg::OFS_CTRL, 32'h0000_0016);
        chk(irq, 32'h0000_0000, "irq idle");
        want_code <= 12'h064;
        cyc(5);
        chk(irq, 32'h0000_0001, "irq raised");
        apb(1'h0, aif_pkg::OFS_ISTAT, 32'h0000_0000);
        chk(rd[0], 32'h0000_0001, "warn event");
        want_code <= 12'h7d0;
        cyc(5);
        wr(aif_pkg::OFS_ISTAT, 32'h0000_0001);
        cyc(2);
        chk(irq, 32'h0000_0000, "irq cleared");
        wr(aif_pkg::OFS_IMASK, 32'h0000_0000);
        want_code <= 12'h064;
        cyc(5);
        chk({warn, irq}, 32'h0000_0002, "irq masked");
        wr(aif_pkg::OFS_CTRL, 32'h0000_0004);
        want_level <= 1'h1;
        wait_for(dig_proc, 1'h1);
        cyc(2);
        chk(thermal_contact, 32'h0000_0001, "raw source");
        want_level <= 1'h0;
        cyc(4);
        chk({dig_raw, thermal_contact, dig_proc}, 32'h0000_0001,
            "raw ahead");
        wr(aif_pkg::OFS_TSEL, 32'h0000_004d);
        wait_for(dig_proc, 1'h0);
        want_level <= 1'h1;
        cyc(4);
        chk({dig_raw, thermal_contact}, 32'h0000_0002, "proc source");
        rstn <= 1'h0;
        cyc(2);
        rstn <= 1'h1;
        rdc(aif_pkg::OFS_TSEL, 32'h0000_0214);
        print_verdict();
    end

    // Whole run is several hundred cycles
    initial begin
        cyc(40000);
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
